// [logic/gcc_consts.svh]
// Constants of the gauge calibration command block.
// Pressures: signed raw, LSB 1e-5 Torr, 1e-5 mbar or 1e-3 Pa.
`ifndef GCC_CONSTS_SVH
`define GCC_CONSTS_SVH
`define GCC_DEV_ADDR 8'hFD
`define GCC_A_CMD 12'h000
`define GCC_A_ARG 12'h004
`define GCC_A_RPL 12'h008
`define GCC_A_CFG 12'h00C
`define GCC_A_ZD 12'h010
`define GCC_A_SD 12'h014
`define GCC_A_PZ 12'h018
`define GCC_A_ABS 12'h01C
`define GCC_A_GAIN 12'h020
`define GCC_A_PIR 12'h024
`define GCC_A_DIF 12'h028
`define GCC_A_CMB 12'h02C
`define GCC_A_SP0 12'h030
`define GCC_A_SP2 12'h038
`define GCC_R_ACK 8'h00
`define GCC_R_BAD 8'h02
`define GCC_R_HIGH 8'h08
`define GCC_R_LOCK 8'hB4
`define GCC_GAS_MAX 8'h07
`define GCC_UNIT_MAX 8'h02
`define GCC_SP_MAX 8'h02
`define GCC_P_ZERO 0
`define GCC_P_SPAN 1
`define GCC_P_PZ 2
`define GCC_P_ABS 3
`define GCC_P_SP 4
`define GCC_P_N 7
`define GCC_ZLO_T 32'sd1
`define GCC_ZLO_M 32'sd1
`define GCC_ZHI_T 32'sd500
`define GCC_ZHI_M 32'sd667
`define GCC_ZHIGH_T 32'sd1000
`define GCC_ZHIGH_M 32'sd1333
`define GCC_ATM_LO_T 32'sd50000000
`define GCC_ATM_LO_M 32'sd66661000
`define GCC_ATM_HI_T 32'sd78000000
`define GCC_ATM_HI_M 32'sd103991000
`define GCC_AIR_T 32'sd40000000
`define GCC_AIR_M 32'sd53329000
`define GCC_ATD_HI_T 32'sd80000000
`define GCC_ATD_HI_M 32'sd106658000
`define GCC_ATS_LO_T 32'sd10000000
`define GCC_ATS_LO_M 32'sd13332200
`define GCC_ATS_HI_T 32'sd76000000
`define GCC_ATS_HI_M 32'sd101325000
`define GCC_AUTO_T 32'sd120000
`define GCC_AUTO_M 32'sd159987
`define GCC_TEN_T 32'sd1000000
`define GCC_TEN_M 32'sd1333224
`define GCC_FAC_ABS `GCC_ATS_HI_M
`define GCC_FAC_SP 32'sd133322
`define GCC_GAIN_ONE 32'sd65536
`define GCC_GAIN_SH 4
`define GCC_K_T2M 32'sd87374
`define GCC_K_M2T 32'sd49156
`define GCC_DIV_LAST 6'd47
`define GCC_FLASH_PH 3'd6
`define GCC_CLK_HZ 20000000
`define GCC_SW_HOLD_S 2
`define GCC_FLASH_MS 250
`endif

// [logic/gcc_pkg.sv]
// Types of the gauge calibration command block.
// Numbers live in gcc_consts.svh.
`default_nettype none
package gcc_pkg;
  typedef enum logic [1:0] {GCC_U_TORR = 2'b00, GCC_U_MBAR = 2'b01,
    GCC_U_PASCAL = 2'b10} gcc_unit_e;
  typedef enum logic [7:0] {OP_GAS = 8'h01, OP_UNIT = 8'h02, OP_VAC = 8'h03,
    OP_ATM = 8'h04, OP_ATZ = 8'h05, OP_ATD = 8'h06, OP_ATS = 8'h07,
    OP_FD = 8'h08, OP_SP = 8'h09} gcc_op_e;
  typedef enum logic [7:0] {FD_CAL = 8'h00, FD_ALL = 8'h01, FD_UNLOCK = 8'h02,
    FD_LOCK = 8'h03, FD_VAC = 8'h04, FD_ATM = 8'h05, FD_ATZ = 8'h06,
    FD_ATS = 8'h07, FD_ATD = 8'h08} gcc_fd_e;
  typedef enum logic {ST_IDLE = 1'b0, ST_DIV = 1'b1} gcc_state_e;
  typedef logic signed [31:0] gcc_press_t;
endpackage
`default_nettype wire

// [logic/gcc_cal_core.sv]
// Gauge calibration command block: APB slave running calibration commands.
// Assumes readings arrive on pclk in the active unit; switch is a raw pin.
// Summary of operation
// - Gas select addressed to 253 takes one of eight gases, echoes it, readable.
// - Nitrogen curve is used until another gas is selected.
// - Unit select takes Torr, mbar or Pascal only, echoes it, readable.
// - Unit change converts every stored pressure, setpoints too, to same pressure.
// - Every pressure argument is read in the active unit.
// - Pirani zero takes no argument or a value in range; plain acknowledge.
// - Pirani zero is refused as sensor-too-high above about 1e-2 Torr.
// - Zero query returns user offset minus factory offset.
// - Two-second switch press starts zero; LED flashes green or red three times.
// - Pirani span needs an in-range pressure; plain acknowledge.
// - Span query returns user span minus factory span.
// - Piezo zero nulls differential offset; sensor-too-high when not at atmosphere.
// - Two-second press at atmosphere does piezo zero with the same LED flashes.
// - Below 1.2 Torr absolute offset recomputed; stored only if off by over 10 Torr.
// - Absolute offset needs an in-range pressure; acknowledged and applied.
// - Combined reading equals the entered offset at zero differential.
// - Piezo full scale needs in-range pressure; acknowledged, rescales differential.
// - Offset and full scale refused as sensor-too-high when signal out of bounds.
// - Restore defaults: all, lock, unlock or one adjustment at a time.
// - While locked, changes are refused with the locked reply code.
//
// The register addresses and register access over APB were left to the implementer.
`include "gcc_consts.svh"
`default_nettype none
module gcc_cal_core #(
  parameter int unsigned HOLD_CYC = `GCC_SW_HOLD_S * `GCC_CLK_HZ,
  parameter int unsigned FLASH_CYC = `GCC_FLASH_MS * (`GCC_CLK_HZ / 1000),
  parameter logic LOCK_RST = 1'b0,
  parameter logic signed [31:0] FAC_ZERO = 32'sh0,
  parameter logic signed [31:0] FAC_SPAN = 32'sh0,
  parameter logic signed [31:0] FAC_PZ = 32'sh0,
  parameter logic signed [31:0] FAC_GAIN = `GCC_GAIN_ONE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gcc_pkg::gcc_press_t pirani_reading,
  input wire gcc_pkg::gcc_press_t piezo_diff_reading,
  input wire logic user_sw_n,
  output logic led_green,
  output logic led_red,
  output logic nvm_wr,
  output gcc_pkg::gcc_press_t nvm_data,
  output gcc_pkg::gcc_press_t pirani_out,
  output gcc_pkg::gcc_press_t diff_out,
  output gcc_pkg::gcc_press_t combined_abs_reading
);
  import gcc_pkg::*;

  function automatic gcc_press_t conv(input gcc_press_t x, input logic fm, input logic tm);
    logic signed [63:0] p;
    p = 64'(x) * 64'(tm ? `GCC_K_T2M : `GCC_K_M2T);
    return (fm == tm) ? x : p[47:16];
  endfunction

  function automatic gcc_press_t pick(input logic m, input gcc_press_t t, input gcc_press_t mv);
    return m ? mv : t;
  endfunction

  function automatic logic rng(input gcc_press_t a, input gcc_press_t lo, input gcc_press_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Factory values are held in metric raw and converted on use
  function automatic gcc_press_t fac(input int i, input logic m);
    gcc_press_t f;
    case (i)
      `GCC_P_ZERO: f = FAC_ZERO;
      `GCC_P_SPAN: f = FAC_SPAN;
      `GCC_P_PZ: f = FAC_PZ;
      `GCC_P_ABS: f = `GCC_FAC_ABS;
      default: f = `GCC_FAC_SP;
    endcase
    return conv(f, 1'b1, m);
  endfunction

  function automatic logic fd_hit(input int i, input logic [7:0] s);
    logic cal;
    cal = (s == FD_CAL) || (s == FD_ALL);
    case (i)
      `GCC_P_ZERO: return cal || (s == FD_VAC);
      `GCC_P_SPAN: return cal || (s == FD_ATM);
      `GCC_P_PZ: return cal || (s == FD_ATZ);
      `GCC_P_ABS: return cal || (s == FD_ATD);
      default: return s == FD_ALL;
    endcase
  endfunction

  logic [2:0] gas_q;
  gcc_unit_e unit_q;
  logic lock_q;
  gcc_press_t p_q [0:`GCC_P_N-1];
  gcc_press_t gain_q;
  gcc_press_t arg_q;
  logic [7:0] rpl_q;
  logic [7:0] echo_q;
  gcc_state_e st_q;
  logic [47:0] dvd_q;
  logic [31:0] rem_q;
  logic [31:0] dvs_q;
  logic [5:0] cnt_q;
  logic [31:0] prdata_q;
  logic sw_s1_q;
  logic sw_s2_q;
  logic [31:0] hold_q;
  logic [2:0] led_n_q;
  logic [31:0] led_t_q;
  logic led_ok_q;
  logic nvm_wr_q;
  gcc_press_t nvm_data_q;
  logic [7:0] code_w;
  logic [31:0] rd_w;

  wire metric = unit_q != GCC_U_TORR;
  wire acc = psel & penable;
  wire wr_w = acc & pwrite;
  // Pressures stored in the unit of the moment; arguments compared as given
  wire gcc_press_t span_add = (pirani_reading >= pick(metric, `GCC_TEN_T, `GCC_TEN_M))
    ? p_q[`GCC_P_SPAN] : 32'sh0;
  wire gcc_press_t pir_w = pirani_reading - p_q[`GCC_P_ZERO] + span_add;
  wire gcc_press_t dcor = piezo_diff_reading - p_q[`GCC_P_PZ];
  wire logic signed [63:0] prod_w = 64'(dcor) * 64'(gain_q);
  wire gcc_press_t diff_w = prod_w[47:16];
  wire gcc_press_t cmb_w = p_q[`GCC_P_ABS] + diff_w;
  wire gcc_press_t mag_w = (dcor < 0) ? -dcor : dcor;
  wire gcc_press_t cand = -diff_w;
  wire gcc_press_t dlt = cand - p_q[`GCC_P_ABS];
  wire gcc_press_t dlt_mag = (dlt < 0) ? -dlt : dlt;
  wire at_air = pir_w >= pick(metric, `GCC_AIR_T, `GCC_AIR_M);
  wire too_high = pir_w > pick(metric, `GCC_ZHIGH_T, `GCC_ZHIGH_M);

  // Commands not for this address are dropped silently, like a serial bus
  wire cmd_wr = wr_w && (paddr == `GCC_A_CMD) && (pwdata[23:16] == `GCC_DEV_ADDR)
    && (st_q == ST_IDLE);
  wire sw_press = !sw_s2_q;
  wire sw_fire = sw_press && (hold_q == HOLD_CYC - 1);
  wire go_sw = sw_fire && !cmd_wr && (st_q == ST_IDLE);
  wire go = cmd_wr | go_sw;
  wire gcc_op_e op_w = cmd_wr ? gcc_op_e'(pwdata[7:0]) : (!too_high ? OP_VAC : OP_ATZ);
  wire [7:0] sel_w = cmd_wr ? pwdata[15:8] : 8'h00;
  wire has_w = cmd_wr & pwdata[24];
  wire gcc_press_t ztgt = has_w ? arg_q : pick(metric, `GCC_ZLO_T, `GCC_ZLO_M);
  wire lock_hit = lock_q && !((op_w == OP_FD) && ((sel_w == FD_UNLOCK) || (sel_w == FD_LOCK)));
  wire ok_w = go && (code_w == `GCC_R_ACK);
  wire div_go = ok_w && (op_w == OP_ATS);
  wire [32:0] rem_n = {rem_q, dvd_q[47]};
  wire qbit = rem_n >= {1'b0, dvs_q};
  wire div_done = (st_q == ST_DIV) && (cnt_q == `GCC_DIV_LAST);
  wire auto_w = !go && (st_q == ST_IDLE) && (pir_w < pick(metric, `GCC_AUTO_T, `GCC_AUTO_M))
    && (dlt_mag > pick(metric, `GCC_TEN_T, `GCC_TEN_M));
  wire led_on = (led_n_q != 3'd0) && !led_n_q[0];
  wire hit_w = (paddr[1:0] == 2'b00) && (paddr <= `GCC_A_SP2);

  // Lock first, then argument range, then sensor condition
  always_comb begin
    code_w = `GCC_R_ACK;
    if (lock_hit) begin
      code_w = `GCC_R_LOCK;
    end else begin
      unique case (op_w)
        OP_GAS: if (sel_w > `GCC_GAS_MAX) code_w = `GCC_R_BAD;
        OP_UNIT: if (sel_w > `GCC_UNIT_MAX) code_w = `GCC_R_BAD;
        OP_VAC: begin
          if (has_w && !rng(arg_q, pick(metric, `GCC_ZLO_T, `GCC_ZLO_M),
              pick(metric, `GCC_ZHI_T, `GCC_ZHI_M))) code_w = `GCC_R_BAD;
          else if (too_high) code_w = `GCC_R_HIGH;
        end
        OP_ATM: if (!rng(arg_q, pick(metric, `GCC_ATM_LO_T, `GCC_ATM_LO_M),
            pick(metric, `GCC_ATM_HI_T, `GCC_ATM_HI_M))) code_w = `GCC_R_BAD;
        OP_ATZ: if (!at_air) code_w = `GCC_R_HIGH;
        OP_ATD: begin
          if (!rng(arg_q, pick(metric, `GCC_AIR_T, `GCC_AIR_M),
              pick(metric, `GCC_ATD_HI_T, `GCC_ATD_HI_M))) code_w = `GCC_R_BAD;
          else if (!at_air) code_w = `GCC_R_HIGH;
        end
        OP_ATS: begin
          if (!rng(arg_q, pick(metric, `GCC_ATS_LO_T, `GCC_ATS_LO_M),
              pick(metric, `GCC_ATS_HI_T, `GCC_ATS_HI_M))) code_w = `GCC_R_BAD;
          else if (mag_w < (arg_q >>> `GCC_GAIN_SH)) code_w = `GCC_R_HIGH;
        end
        OP_FD: if (sel_w > FD_ATD) code_w = `GCC_R_BAD;
        OP_SP: if (sel_w > `GCC_SP_MAX) code_w = `GCC_R_BAD;
        default: code_w = `GCC_R_BAD;
      endcase
    end
  end

  always_comb begin
    rd_w = 32'h0;
    case (paddr)
      `GCC_A_ARG: rd_w = arg_q;
      `GCC_A_RPL: rd_w = {15'h0, st_q, echo_q, rpl_q};
      `GCC_A_CFG: rd_w = {23'h0, lock_q, 2'b00, unit_q, 1'b0, gas_q};
      `GCC_A_ZD: rd_w = p_q[`GCC_P_ZERO] - fac(`GCC_P_ZERO, metric);
      `GCC_A_SD: rd_w = p_q[`GCC_P_SPAN] - fac(`GCC_P_SPAN, metric);
      `GCC_A_PZ: rd_w = p_q[`GCC_P_PZ];
      `GCC_A_ABS: rd_w = p_q[`GCC_P_ABS];
      `GCC_A_GAIN: rd_w = gain_q;
      `GCC_A_PIR: rd_w = pir_w;
      `GCC_A_DIF: rd_w = diff_w;
      `GCC_A_CMB: rd_w = cmb_w;
      default: if (hit_w && paddr >= `GCC_A_SP0) rd_w = p_q[`GCC_P_SP + int'(paddr[3:2])];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      arg_q <= 32'sh0;
    end else begin
      if (psel && !penable) prdata_q <= rd_w;
      if (wr_w && paddr == `GCC_A_ARG) arg_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gas_q <= 3'h0;
      unit_q <= GCC_U_PASCAL;
      lock_q <= LOCK_RST;
      gain_q <= FAC_GAIN;
      rpl_q <= `GCC_R_ACK;
      echo_q <= 8'h00;
      for (int i = 0; i < `GCC_P_N; i++) p_q[i] <= fac(i, 1'b1);
    end else begin
      if (go) rpl_q <= code_w;
      if (div_done) gain_q <= {dvd_q[30:0], qbit};
      if (auto_w) p_q[`GCC_P_ABS] <= cand;
      if (ok_w) begin
        unique case (op_w)
          OP_GAS: begin
            gas_q <= sel_w[2:0];
            echo_q <= sel_w;
          end
          OP_UNIT: begin
            unit_q <= gcc_unit_e'(sel_w[1:0]);
            echo_q <= sel_w;
            for (int i = 0; i < `GCC_P_N; i++)
              p_q[i] <= conv(p_q[i], metric, sel_w[1:0] != GCC_U_TORR);
          end
          OP_VAC: p_q[`GCC_P_ZERO] <= pirani_reading - ztgt;
          OP_ATM: p_q[`GCC_P_SPAN] <= arg_q - (pirani_reading - p_q[`GCC_P_ZERO]);
          OP_ATZ: p_q[`GCC_P_PZ] <= piezo_diff_reading;
          OP_ATD: p_q[`GCC_P_ABS] <= arg_q;
          OP_SP: p_q[`GCC_P_SP + int'(sel_w[1:0])] <= arg_q;
          OP_FD: begin
            if (sel_w == FD_UNLOCK) lock_q <= 1'b0;
            if (sel_w == FD_LOCK) lock_q <= 1'b1;
            if (sel_w == FD_CAL || sel_w == FD_ALL) gas_q <= 3'h0;
            if (sel_w == FD_ALL) unit_q <= GCC_U_PASCAL;
            if (sel_w == FD_CAL || sel_w == FD_ALL || sel_w == FD_ATS) gain_q <= FAC_GAIN;
            for (int i = 0; i < `GCC_P_N; i++)
              if (fd_hit(i, sel_w)) p_q[i] <= fac(i, metric || sel_w == FD_ALL);
          end
          default: ;
        endcase
      end
    end
  end

  // Gain = applied / measured in Q16, one quotient bit per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      dvd_q <= 48'h0;
      rem_q <= 32'h0;
      dvs_q <= 32'h0;
      cnt_q <= 6'h0;
    end else if (div_go) begin
      st_q <= ST_DIV;
      dvd_q <= {arg_q, 16'h0};
      rem_q <= 32'h0;
      dvs_q <= mag_w;
      cnt_q <= 6'h0;
    end else if (st_q == ST_DIV) begin
      dvd_q <= {dvd_q[46:0], qbit};
      rem_q <= qbit ? 32'(rem_n - {1'b0, dvs_q}) : rem_n[31:0];
      cnt_q <= cnt_q + 6'h1;
      if (div_done) st_q <= ST_IDLE;
    end
  end

  // Switch pin is asynchronous; two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_q <= 1'b1;
      sw_s2_q <= 1'b1;
      hold_q <= 32'h0;
    end else begin
      sw_s1_q <= user_sw_n;
      sw_s2_q <= sw_s1_q;
      if (!sw_press) hold_q <= 32'h0;
      else if (hold_q != HOLD_CYC) hold_q <= hold_q + 32'h1;
    end
  end

  // A press that lands while busy flashes red rather than waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_n_q <= 3'd0;
      led_t_q <= 32'h0;
      led_ok_q <= 1'b0;
    end else if (sw_fire) begin
      led_n_q <= `GCC_FLASH_PH;
      led_t_q <= 32'h0;
      led_ok_q <= go_sw && (code_w == `GCC_R_ACK);
    end else if (led_n_q != 3'd0) begin
      if (led_t_q == FLASH_CYC - 1) begin
        led_t_q <= 32'h0;
        led_n_q <= led_n_q - 3'd1;
      end else begin
        led_t_q <= led_t_q + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_wr_q <= 1'b0;
      nvm_data_q <= 32'sh0;
    end else begin
      nvm_wr_q <= auto_w;
      if (auto_w) nvm_data_q <= cand;
    end
  end

  assign pready = acc;
  assign pslverr = acc & !hit_w;
  assign prdata = prdata_q;
  assign led_green = led_on & led_ok_q;
  assign led_red = led_on & !led_ok_q;
  assign nvm_wr = nvm_wr_q;
  assign nvm_data = nvm_data_q;
  assign pirani_out = pir_w;
  assign diff_out = diff_w;
  assign combined_abs_reading = cmb_w;
endmodule
`default_nettype wire

// [test/gcc_cal_properties.sv]
// Checker on gcc_cal_core ports: offset store, combined reading, LED flashes.
// Assumes the bench sets FLASH_CYC to 4, so a flash phase lasts four clocks.
`default_nettype none
module gcc_cal_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic led_green,
  input wire logic led_red,
  input wire logic nvm_wr,
  input wire gcc_pkg::gcc_press_t nvm_data,
  input wire gcc_pkg::gcc_press_t pirani_out,
  input wire gcc_pkg::gcc_press_t diff_out,
  input wire gcc_pkg::gcc_press_t combined_abs_reading
);
  timeunit 1ns;
  timeprecision 1ns;
  import gcc_pkg::*;
  gcc_press_t old_abs_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Offset in force one cycle back, rebuilt from the combined reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      old_abs_q <= 32'sh0;
    end else begin
      old_abs_q <= combined_abs_reading - diff_out;
    end
  end
  sequence s_green;
    led_green [*4] ##1 !led_green [*4];
  endsequence
  sequence s_red;
    led_red [*4] ##1 !led_red [*4];
  endsequence
  chk_nvm_pulse: assert property (nvm_wr |=> !nvm_wr)
    else $error("store strobe longer than one cycle");
  // 1.2 Torr is 120000 in Torr and 159987 in the metric units
  chk_nvm_low: assert property (nvm_wr |-> $past(pirani_out) < 32'sd159987)
    else $error("offset stored while pressure high");
  chk_nvm_value: assert property (nvm_wr |-> nvm_data == -$past(diff_out))
    else $error("stored offset is not the inverted differential");
  chk_nvm_dev: assert property (nvm_wr |-> (nvm_data - old_abs_q > 32'sd1000000) ||
      (old_abs_q - nvm_data > 32'sd1000000))
    else $error("offset stored with small deviation");
  chk_comb_offset: assert property (nvm_wr |-> combined_abs_reading == nvm_data + diff_out)
    else $error("combined reading ignores new offset");
  chk_led_excl: assert property (!(led_green && led_red))
    else $error("both LED colours lit");
  chk_green_flash: assert property ($rose(led_green) |-> s_green)
    else $error("green flash phase wrong");
  chk_red_flash: assert property ($rose(led_red) |-> s_red)
    else $error("red flash phase wrong");
endmodule
bind gcc_cal_core gcc_cal_properties i_gcc_cal_properties (.pclk(pclk), .presetn(presetn),
  .led_green(led_green), .led_red(led_red), .nvm_wr(nvm_wr), .nvm_data(nvm_data),
  .pirani_out(pirani_out), .diff_out(diff_out), .combined_abs_reading(combined_abs_reading));
`default_nettype wire

// [test/gcc_sensor_model.sv]
// Sensor front end and push switch as seen by the calibration block.
// Assumes the bench gives pressures already in the active unit.
`default_nettype none
module gcc_sensor_model (
  input wire logic pclk,
  input wire gcc_pkg::gcc_press_t pir_set,
  input wire gcc_pkg::gcc_press_t dif_set,
  input wire logic press_start,
  output gcc_pkg::gcc_press_t pirani_reading,
  output gcc_pkg::gcc_press_t piezo_diff_reading,
  output logic user_sw_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import gcc_pkg::*;
  int hold_cnt = 0;
  // Pulled up whenever released
  assign user_sw_n = (hold_cnt == 0);
  initial begin
    pirani_reading = 32'sh0;
    piezo_diff_reading = 32'sh0;
  end
  always @(posedge pclk) begin
    pirani_reading <= pir_set;
    piezo_diff_reading <= dif_set;
    // Held well past the hold time plus the two-stage sync
    if (press_start) begin
      hold_cnt <= 40;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// [test/gcc_cal_core_tb.sv]
// Bench for gcc_cal_core: commands over APB, sensor model, push switch.
// Assumes short hold and flash counts set here; pressures in raw LSB.
`include "gcc_consts.svh"
`default_nettype none
module gcc_cal_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gcc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, press_start = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic slv;
  logic pready, pslverr, user_sw_n, led_green, led_red, nvm_wr;
  gcc_press_t pirani_reading, piezo_diff_reading, nvm_data, pirani_out, diff_out, comb;
  gcc_press_t pir_set = 32'sd101325000, dif_set = 32'sh0;
  int err_total = 0;
  int n_checks = 0;
  always #25 pclk = ~pclk;
  gcc_cal_core #(.HOLD_CYC(20), .FLASH_CYC(4)) i_gcc_cal_core (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pirani_reading(pirani_reading),
    .piezo_diff_reading(piezo_diff_reading), .user_sw_n(user_sw_n), .led_green(led_green),
    .led_red(led_red), .nvm_wr(nvm_wr), .nvm_data(nvm_data), .pirani_out(pirani_out),
    .diff_out(diff_out), .combined_abs_reading(comb));
  gcc_sensor_model i_gcc_sensor_model (.pclk(pclk), .pir_set(pir_set), .dif_set(dif_set),
    .press_start(press_start), .pirani_reading(pirani_reading),
    .piezo_diff_reading(piezo_diff_reading), .user_sw_n(user_sw_n));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle cycle after each transfer, so no strobe is driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] sel, input logic has,
      input gcc_press_t arg, input logic [7:0] code);
    int n;
    apb(1'b1, `GCC_A_ARG, arg);
    apb(1'b1, `GCC_A_CMD, {7'h00, has, `GCC_DEV_ADDR, sel, op});
    n = 0;
    do begin
      apb(1'b0, `GCC_A_RPL, 32'h0);
      n++;
    end while (rd[16] === 1'b1 && n < 200);
    check("busy", 32'h0, {31'h0, rd[16]});
    check("reply code", {24'h0, code}, {24'h0, rd[7:0]});
  endtask
  task automatic t_gas();
    for (int g = 7; g >= 0; g--) begin
      cmd(OP_GAS, 8'(g), 1'b0, 32'sh0, `GCC_R_ACK);
      check("gas echo", 32'(g), {24'h0, rd[15:8]});
      rd_check("gas config", `GCC_A_CFG, 32'h20 | 32'(g));
    end
    apb(1'b1, `GCC_A_CMD, {8'h00, 8'h01, 8'h03, OP_GAS});
    rd_check("foreign address", `GCC_A_CFG, 32'h20);
    cmd(OP_GAS, 8'h08, 1'b0, 32'sh0, `GCC_R_BAD);
    rd_check("gas kept", `GCC_A_CFG, 32'h20);
    apb(1'b0, 12'h03C, 32'h0);
    check("bus error", 32'h1, {31'h0, slv});
  endtask
  task automatic t_unit();
    for (int u = 3; u >= 0; u--) begin
      cmd(OP_UNIT, 8'(u), 1'b0, 32'sh0, u == 3 ? `GCC_R_BAD : `GCC_R_ACK);
      if (u < 3) check("unit echo", 32'(u), {24'h0, rd[15:8]});
    end
    rd_check("torr config", `GCC_A_CFG, 32'h0);
    apb(1'b0, `GCC_A_SP0, 32'h0);
    // Conversion rounding leaves a few LSB of slack
    check("setpoint", 32'h1, 32'($signed(rd) inside {[99997:100003]}));
  endtask
  task automatic t_zero();
    pir_set <= 32'sd2000;
    cmd(OP_VAC, 8'h00, 1'b0, 32'sh0, `GCC_R_HIGH);
    pir_set <= 32'sd8;
    dif_set <= -32'sd75000000;
    repeat (3) @(posedge pclk);
    rd_check("auto offset", `GCC_A_ABS, 32'sd75000000);
    cmd(OP_VAC, 8'h00, 1'b1, 32'sd600, `GCC_R_BAD);
    cmd(OP_VAC, 8'h00, 1'b0, 32'sh0, `GCC_R_ACK);
    rd_check("zeroed reading", `GCC_A_PIR, 32'sd1);
    rd_check("zero delta", `GCC_A_ZD, 32'sd7);
    dif_set <= -32'sd75500000;
    repeat (3) @(posedge pclk);
    rd_check("offset kept", `GCC_A_ABS, 32'sd75000000);
  endtask
  task automatic t_span();
    pir_set <= 32'sd75000000;
    dif_set <= 32'sd500;
    cmd(OP_ATM, 8'h00, 1'b1, `GCC_ATM_HI_T + 1, `GCC_R_BAD);
    cmd(OP_ATM, 8'h00, 1'b1, `GCC_ATS_HI_T, `GCC_R_ACK);
    rd_check("span reading", `GCC_A_PIR, `GCC_ATS_HI_T);
    rd_check("span delta", `GCC_A_SD, 32'sd1000007);
  endtask
  task automatic t_piezo();
    cmd(OP_ATZ, 8'h00, 1'b0, 32'sh0, `GCC_R_ACK);
    rd_check("diff zeroed", `GCC_A_DIF, 32'h0);
    cmd(OP_ATD, 8'h00, 1'b1, `GCC_ATD_HI_T + 1, `GCC_R_BAD);
    cmd(OP_ATD, 8'h00, 1'b1, 32'sd74000000, `GCC_R_ACK);
    rd_check("combined", `GCC_A_CMB, 32'sd74000000);
    cmd(OP_ATS, 8'h00, 1'b1, `GCC_ATS_HI_T, `GCC_R_HIGH);
    dif_set <= 32'sd50000500;
    cmd(OP_ATS, 8'h00, 1'b1, 32'sd60000000, `GCC_R_ACK);
    check("scaled diff", 32'h1, 32'(diff_out inside {[59998000:60002000]}));
    pir_set <= 32'sd30000000;
    cmd(OP_ATZ, 8'h00, 1'b0, 32'sh0, `GCC_R_HIGH);
  endtask
  task automatic t_lock();
    cmd(OP_FD, FD_LOCK, 1'b0, 32'sh0, `GCC_R_ACK);
    cmd(OP_GAS, 8'h01, 1'b0, 32'sh0, `GCC_R_LOCK);
    cmd(OP_FD, FD_UNLOCK, 1'b0, 32'sh0, `GCC_R_ACK);
    cmd(OP_FD, FD_VAC, 1'b0, 32'sh0, `GCC_R_ACK);
    rd_check("zero restored", `GCC_A_ZD, 32'h0);
    cmd(OP_SP, 8'h01, 1'b1, 32'sd12345, `GCC_R_ACK);
    rd_check("setpoint two", `GCC_A_SP0 + 12'h004, 32'sd12345);
    // Full restore puts the unit back to Pascal for the switch tests
    cmd(OP_FD, FD_ALL, 1'b0, 32'sh0, `GCC_R_ACK);
    rd_check("all restored", `GCC_A_CFG, 32'h20);
    rd_check("setpoint reset", `GCC_A_SP0 + 12'h004, `GCC_FAC_SP);
  endtask
  task automatic t_switch(input gcc_press_t p, input logic green);
    int n;
    pir_set <= p;
    press_start <= 1'b1;
    @(posedge pclk);
    press_start <= 1'b0;
    n = 0;
    while (led_green !== 1'b1 && led_red !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check("green lamp", {31'h0, green}, {31'h0, led_green});
    check("red lamp", {31'h0, !green}, {31'h0, led_red});
    repeat (40) @(posedge pclk);
  endtask
  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_check("reset config", `GCC_A_CFG, 32'h20);
    check("bus error", 32'h0, {31'h0, slv});
    t_gas();
    t_unit();
    t_zero();
    t_span();
    t_piezo();
    t_lock();
    t_switch(32'sd76000000, 1'b1);
    t_switch(32'sd2000, 1'b0);
    t_switch(32'sd8, 1'b1);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
